// File: pstc_pkg.sv
/*
 * Shared constants for the strap-pin configuration loader of the
 * four-source high speed and auxiliary switch.
 * Assumes a single 100 MHz clock and a synchronous active-high reset.
 */
package pstc_pkg;

    localparam int REG_W = 8;
    localparam int IDX_W = 3;

    // Register indices on the decoded serial register port
    localparam logic [2:0] FAST_MODE_IDX = 3'h0;
    localparam logic [2:0] SIDE_MODE_IDX = 3'h1;
    localparam logic [2:0] IN_TERM_IDX = 3'h2;
    localparam logic [2:0] PULSE_AB_IDX = 3'h3;
    localparam logic [2:0] PULSE_CD_IDX = 3'h4;
    localparam logic [2:0] EQ_AB_IDX = 3'h5;
    localparam logic [2:0] EQ_CD_IDX = 3'h6;
    localparam logic [2:0] OUT_DRIVE_IDX = 3'h7;

    // Field positions in the two device mode registers
    localparam int MODE_EN_BIT = 6;
    localparam int MODE_SEL_LSB = 2;
    localparam int MODE_SEL_MSB = 5;
    localparam int SRC_LSB = 0;
    localparam int SRC_MSB = 1;

    // Field positions in the receiver and transmitter registers
    localparam int IN_TERM_BIT = 0;
    localparam int EMPH_LSB = 2;
    localparam int EMPH_MSB = 3;
    localparam int OUT_TERM_BIT = 1;
    localparam int OUT_DRIVE_BIT = 0;

    // Forced values while the straps govern the registers
    localparam logic [3:0] QUAD_MODE = 4'h0;
    localparam logic SIDE_FORCED_ON = 1'b1;
    localparam logic IN_TERM_FORCED_ON = 1'b1;
    localparam logic [7:0] PULSE_FORCED = 8'h00;

    // Values after reset
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic STRAP_MODE_RST = 1'b1;
    localparam logic [7:0] RDATA_RST = 8'h00;
    localparam logic [3:0] ONEHOT_RST = 4'h0;
    localparam logic [15:0] CHAN_RST = 16'h0000;

    // Pre-emphasis codes
    localparam logic [1:0] EMPH_NONE = 2'h0;
    localparam logic [1:0] EMPH_LOW = 2'h1;
    localparam logic [1:0] EMPH_MED = 2'h2;
    localparam logic [1:0] EMPH_HIGH = 2'h3;

    typedef enum logic [1:0] {
        PSTC_SRC_A = 2'b00,
        PSTC_SRC_B = 2'b01,
        PSTC_SRC_C = 2'b10,
        PSTC_SRC_D = 2'b11
    } pstc_src_t;

    typedef enum logic [0:0] {
        PSTC_CFG_STRAP = 1'b0,
        PSTC_CFG_SERIAL = 1'b1
    } pstc_cfg_t;

endpackage

// File: pstc_cfg_reg.sv
/*
 * One eight-bit configuration register that follows a strap-derived
 * value until the serial side takes over, then keeps serial writes.
 * Assumes the caller decodes the write strobe for this register.
 */
`timescale 1ns/1ps
module pstc_cfg_reg (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic strap_mode_in,
    input wire logic [7:0] strap_val_in,
    input wire logic wr_en_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] q_out
);

    logic [7:0] q_ff;
    logic [7:0] nxt_q;

    always_comb begin
        nxt_q = q_ff;
        if (wr_en_in) begin
            nxt_q = wdata_in;
        end else if (strap_mode_in) begin
            nxt_q = strap_val_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            q_ff <= pstc_pkg::REG_RST;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign q_out = q_ff;

endmodule

// File: pstc_src_decode.sv
/*
 * Two-bit source code to one-hot source select, gated by an enable.
 * Assumes quad switching; other modes give no one-hot route.
 */
`timescale 1ns/1ps
module pstc_src_decode (
    input wire logic enable_in,
    input wire logic [3:0] mode_in,
    input wire logic [1:0] src_in,
    output logic [3:0] onehot_out
);

    always_comb begin
        onehot_out = 4'h0;
        if (enable_in && (mode_in == pstc_pkg::QUAD_MODE)) begin
            case (pstc_pkg::pstc_src_t'(src_in))
                pstc_pkg::PSTC_SRC_A: onehot_out = 4'h1;
                pstc_pkg::PSTC_SRC_B: onehot_out = 4'h2;
                pstc_pkg::PSTC_SRC_C: onehot_out = 4'h4;
                pstc_pkg::PSTC_SRC_D: onehot_out = 4'h8;
                default: onehot_out = 4'h0;
            endcase
        end
    end

endmodule

// File: pstc_top.sv
/*
 * Strap-pin configuration loader: composes the eight switch
 * configuration registers from static strap pins after reset, hands
 * them to the serial side on its first access, and decodes them into
 * the controls of the analog switch paths.
 * Assumes strap pins are static levels synchronous to clk_in and that
 * the serial control block presents already-decoded register accesses.
 */
`timescale 1ns/1ps
// Function
// - Output termination bit turns all fast output terminations off at 0, on at 1.
// - Output drive bit selects 10 mA when clear, 20 mA when set.
// - Registers load from straps; board ties each strap high or low.
// - Straps govern only after reset and until any serial register access.
// - Strap mode forces fast switching to quad, mode field zero.
// - Fast enable strap puts fast channels in standby at 0, on at 1.
// - Source select codes 00 to 11 route fast sources A to D.
// - Strap mode forces auxiliary switch enabled and in quad mode.
// - Same source select codes route auxiliary sources A to D.
// - Strap mode forces input termination enable bit 0 to 1.
// - Strap mode forces both termination pulse registers to zero.
// - Every bit of both equalizer registers copies the equalization strap.
// - Transmitter register takes emphasis, output termination, drive straps.
// - Fast mode register: enable bit 6, zeros 5 to 2, source 1:0.
// - Auxiliary mode register: one at bit 6, zeros, source 1:0.
// - Emphasis code selects none, low, medium or high for all channels.
// - Equalization strap selects low at 0, high at 1, all inputs.
module pstc_top (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic strap_fast_path_on_in,
    input wire logic [1:0] strap_source_sel_in,
    input wire logic strap_eq_high_in,
    input wire logic [1:0] strap_emph_level_in,
    input wire logic strap_out_term_on_in,
    input wire logic strap_out_drive_high_in,
    input wire logic ser_wr_in,
    input wire logic ser_rd_in,
    input wire logic [2:0] ser_addr_in,
    input wire logic [7:0] ser_wdata_in,
    output logic [7:0] ser_rdata_out,
    output logic ser_rvalid_out,
    output logic strap_active_out,
    output logic fast_path_on_out,
    output logic [3:0] fast_mode_out,
    output logic [3:0] fast_src_onehot_out,
    output logic side_path_on_out,
    output logic [3:0] side_mode_out,
    output logic [3:0] side_common_lines_src_out,
    output logic in_term_on_out,
    output logic [15:0] term_pulse_out,
    output logic [15:0] eq_high_out,
    output logic [1:0] emph_level_out,
    output logic emph_active_out,
    output logic out_term_on_out,
    output logic out_drive_high_out
);

    logic strap_mode_ff;
    logic nxt_strap_mode;
    logic ser_access;

    logic [7:0] strap_fast_mode;
    logic [7:0] strap_side_mode;
    logic [7:0] strap_in_term;
    logic [7:0] strap_eq;
    logic [7:0] strap_out_drive;

    logic [7:0] wr_sel;
    logic [7:0] fast_mode_q;
    logic [7:0] side_mode_q;
    logic [7:0] in_term_q;
    logic [7:0] pulse_ab_q;
    logic [7:0] pulse_cd_q;
    logic [7:0] eq_ab_q;
    logic [7:0] eq_cd_q;
    logic [7:0] out_drive_q;

    logic [3:0] fast_onehot;
    logic [3:0] side_onehot;

    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic rvalid_ff;

    logic fast_on_ff;
    logic [3:0] fast_mode_ff;
    logic [3:0] fast_src_ff;
    logic side_on_ff;
    logic [3:0] side_mode_ff;
    logic [3:0] side_src_ff;
    logic in_term_ff;
    logic [15:0] term_pulse_ff;
    logic [15:0] eq_high_ff;
    logic [1:0] emph_ff;
    logic emph_active_ff;
    logic out_term_ff;
    logic out_drive_ff;

    // Configuration ownership

    assign ser_access = ser_wr_in | ser_rd_in;

    // Any access, read or write, hands the registers to the serial side
    // for good; only a reset gives them back to the straps.
    always_comb begin
        nxt_strap_mode = strap_mode_ff;
        if (ser_access) begin
            nxt_strap_mode = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            strap_mode_ff <= pstc_pkg::STRAP_MODE_RST;
        end else begin
            strap_mode_ff <= nxt_strap_mode;
        end
    end

    // Strap compositions of each register

    always_comb begin
        strap_fast_mode = 8'h00;
        strap_fast_mode[pstc_pkg::MODE_EN_BIT] = strap_fast_path_on_in;
        strap_fast_mode[pstc_pkg::MODE_SEL_MSB:pstc_pkg::MODE_SEL_LSB] = pstc_pkg::QUAD_MODE;
        strap_fast_mode[pstc_pkg::SRC_MSB:pstc_pkg::SRC_LSB] = strap_source_sel_in;
    end

    always_comb begin
        strap_side_mode = 8'h00;
        strap_side_mode[pstc_pkg::MODE_EN_BIT] = pstc_pkg::SIDE_FORCED_ON;
        strap_side_mode[pstc_pkg::MODE_SEL_MSB:pstc_pkg::MODE_SEL_LSB] = pstc_pkg::QUAD_MODE;
        strap_side_mode[pstc_pkg::SRC_MSB:pstc_pkg::SRC_LSB] = strap_source_sel_in;
    end

    always_comb begin
        strap_in_term = 8'h00;
        strap_in_term[pstc_pkg::IN_TERM_BIT] = pstc_pkg::IN_TERM_FORCED_ON;
    end

    assign strap_eq = {8{strap_eq_high_in}};

    always_comb begin
        strap_out_drive = 8'h00;
        strap_out_drive[pstc_pkg::EMPH_MSB:pstc_pkg::EMPH_LSB] = strap_emph_level_in;
        strap_out_drive[pstc_pkg::OUT_TERM_BIT] = strap_out_term_on_in;
        strap_out_drive[pstc_pkg::OUT_DRIVE_BIT] = strap_out_drive_high_in;
    end

    // Write decode

    always_comb begin
        wr_sel = 8'h00;
        if (ser_wr_in) begin
            wr_sel[ser_addr_in] = 1'b1;
        end
    end

    // Register storage; a write in the cycle that ends strap mode wins
    // over the strap value of that same cycle.

    pstc_cfg_reg u_fast_mode (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .strap_mode_in(nxt_strap_mode),
        .strap_val_in(strap_fast_mode),
        .wr_en_in(wr_sel[pstc_pkg::FAST_MODE_IDX]),
        .wdata_in(ser_wdata_in),
        .q_out(fast_mode_q)
    );

    pstc_cfg_reg u_side_mode (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .strap_mode_in(nxt_strap_mode),
        .strap_val_in(strap_side_mode),
        .wr_en_in(wr_sel[pstc_pkg::SIDE_MODE_IDX]),
        .wdata_in(ser_wdata_in),
        .q_out(side_mode_q)
    );

    pstc_cfg_reg u_in_term (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .strap_mode_in(nxt_strap_mode),
        .strap_val_in(strap_in_term),
        .wr_en_in(wr_sel[pstc_pkg::IN_TERM_IDX]),
        .wdata_in(ser_wdata_in),
        .q_out(in_term_q)
    );

    pstc_cfg_reg u_pulse_ab (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .strap_mode_in(nxt_strap_mode),
        .strap_val_in(pstc_pkg::PULSE_FORCED),
        .wr_en_in(wr_sel[pstc_pkg::PULSE_AB_IDX]),
        .wdata_in(ser_wdata_in),
        .q_out(pulse_ab_q)
    );

    pstc_cfg_reg u_pulse_cd (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .strap_mode_in(nxt_strap_mode),
        .strap_val_in(pstc_pkg::PULSE_FORCED),
        .wr_en_in(wr_sel[pstc_pkg::PULSE_CD_IDX]),
        .wdata_in(ser_wdata_in),
        .q_out(pulse_cd_q)
    );

    pstc_cfg_reg u_eq_ab (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .strap_mode_in(nxt_strap_mode),
        .strap_val_in(strap_eq),
        .wr_en_in(wr_sel[pstc_pkg::EQ_AB_IDX]),
        .wdata_in(ser_wdata_in),
        .q_out(eq_ab_q)
    );

    pstc_cfg_reg u_eq_cd (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .strap_mode_in(nxt_strap_mode),
        .strap_val_in(strap_eq),
        .wr_en_in(wr_sel[pstc_pkg::EQ_CD_IDX]),
        .wdata_in(ser_wdata_in),
        .q_out(eq_cd_q)
    );

    pstc_cfg_reg u_out_drive (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .strap_mode_in(nxt_strap_mode),
        .strap_val_in(strap_out_drive),
        .wr_en_in(wr_sel[pstc_pkg::OUT_DRIVE_IDX]),
        .wdata_in(ser_wdata_in),
        .q_out(out_drive_q)
    );

    // Read port

    always_comb begin
        case (ser_addr_in)
            pstc_pkg::FAST_MODE_IDX: nxt_rdata = fast_mode_q;
            pstc_pkg::SIDE_MODE_IDX: nxt_rdata = side_mode_q;
            pstc_pkg::IN_TERM_IDX: nxt_rdata = in_term_q;
            pstc_pkg::PULSE_AB_IDX: nxt_rdata = pulse_ab_q;
            pstc_pkg::PULSE_CD_IDX: nxt_rdata = pulse_cd_q;
            pstc_pkg::EQ_AB_IDX: nxt_rdata = eq_ab_q;
            pstc_pkg::EQ_CD_IDX: nxt_rdata = eq_cd_q;
            pstc_pkg::OUT_DRIVE_IDX: nxt_rdata = out_drive_q;
            default: nxt_rdata = pstc_pkg::RDATA_RST;
        endcase
    end

    // Read data holds until the next read so a slow serial shifter can
    // pick it up at its own pace.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rdata_ff <= pstc_pkg::RDATA_RST;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= ser_rd_in;
            if (ser_rd_in) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    // Source routing

    pstc_src_decode u_fast_src (
        .enable_in(fast_mode_q[pstc_pkg::MODE_EN_BIT]),
        .mode_in(fast_mode_q[pstc_pkg::MODE_SEL_MSB:pstc_pkg::MODE_SEL_LSB]),
        .src_in(fast_mode_q[pstc_pkg::SRC_MSB:pstc_pkg::SRC_LSB]),
        .onehot_out(fast_onehot)
    );

    pstc_src_decode u_side_src (
        .enable_in(side_mode_q[pstc_pkg::MODE_EN_BIT]),
        .mode_in(side_mode_q[pstc_pkg::MODE_SEL_MSB:pstc_pkg::MODE_SEL_LSB]),
        .src_in(side_mode_q[pstc_pkg::SRC_MSB:pstc_pkg::SRC_LSB]),
        .onehot_out(side_onehot)
    );

    // Fast path controls; disabled channels drop to standby
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            fast_on_ff <= 1'b0;
            fast_mode_ff <= pstc_pkg::QUAD_MODE;
            fast_src_ff <= pstc_pkg::ONEHOT_RST;
        end else begin
            fast_on_ff <= fast_mode_q[pstc_pkg::MODE_EN_BIT];
            fast_mode_ff <= fast_mode_q[pstc_pkg::MODE_SEL_MSB:pstc_pkg::MODE_SEL_LSB];
            fast_src_ff <= fast_onehot;
        end
    end

    // Auxiliary path controls
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            side_on_ff <= 1'b0;
            side_mode_ff <= pstc_pkg::QUAD_MODE;
            side_src_ff <= pstc_pkg::ONEHOT_RST;
        end else begin
            side_on_ff <= side_mode_q[pstc_pkg::MODE_EN_BIT];
            side_mode_ff <= side_mode_q[pstc_pkg::MODE_SEL_MSB:pstc_pkg::MODE_SEL_LSB];
            side_src_ff <= side_onehot;
        end
    end

    // Input side controls; channel bit n follows the register bit order
    // B0..B3, A0..A3, then C3..C0, D3..D0.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            in_term_ff <= 1'b0;
            term_pulse_ff <= pstc_pkg::CHAN_RST;
            eq_high_ff <= pstc_pkg::CHAN_RST;
        end else begin
            in_term_ff <= in_term_q[pstc_pkg::IN_TERM_BIT];
            term_pulse_ff <= {pulse_cd_q, pulse_ab_q};
            eq_high_ff <= {eq_cd_q, eq_ab_q};
        end
    end

    // Output side controls, shared by all fast channels
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            emph_ff <= pstc_pkg::EMPH_NONE;
            emph_active_ff <= 1'b0;
            out_term_ff <= 1'b0;
            out_drive_ff <= 1'b0;
        end else begin
            emph_ff <= out_drive_q[pstc_pkg::EMPH_MSB:pstc_pkg::EMPH_LSB];
            emph_active_ff <= out_drive_q[pstc_pkg::EMPH_MSB:pstc_pkg::EMPH_LSB] != pstc_pkg::EMPH_NONE;
            out_term_ff <= out_drive_q[pstc_pkg::OUT_TERM_BIT];
            out_drive_ff <= out_drive_q[pstc_pkg::OUT_DRIVE_BIT];
        end
    end

    assign ser_rdata_out = rdata_ff;
    assign ser_rvalid_out = rvalid_ff;
    assign strap_active_out = strap_mode_ff;
    assign fast_path_on_out = fast_on_ff;
    assign fast_mode_out = fast_mode_ff;
    assign fast_src_onehot_out = fast_src_ff;
    assign side_path_on_out = side_on_ff;
    assign side_mode_out = side_mode_ff;
    assign side_common_lines_src_out = side_src_ff;
    assign in_term_on_out = in_term_ff;
    assign term_pulse_out = term_pulse_ff;
    assign eq_high_out = eq_high_ff;
    assign emph_level_out = emph_ff;
    assign emph_active_out = emph_active_ff;
    assign out_term_on_out = out_term_ff;
    assign out_drive_high_out = out_drive_ff;

endmodule

// File: pstc_strap_board.sv
/*
 * Board-side strap model: each pin is tied hard to a rail.
 * Assumes the bench changes the wanted levels only between checks.
 */
`timescale 1ns/1ps
module pstc_strap_board (
    input wire logic [7:0] level_in,
    output logic [7:0] pin_out
);
    // Pins never float: a rail tie gives a clean 1 or 0
    assign pin_out = level_in;
endmodule

// File: pstc_top_assertions.sv
/*
 * Checker for the strap loader top ports.
 * Assumes one clock domain and a bind from the bench top file.
 */
`timescale 1ns/1ps
module pstc_top_chk (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic strap_fast_path_on_in,
    input wire logic [1:0] strap_source_sel_in,
    input wire logic strap_eq_high_in,
    input wire logic [1:0] strap_emph_level_in,
    input wire logic strap_out_term_on_in,
    input wire logic strap_out_drive_high_in,
    input wire logic ser_wr_in,
    input wire logic ser_rd_in,
    input wire logic strap_active_out,
    input wire logic fast_path_on_out,
    input wire logic [3:0] fast_mode_out,
    input wire logic [3:0] fast_src_onehot_out,
    input wire logic side_path_on_out,
    input wire logic [3:0] side_mode_out,
    input wire logic [3:0] side_common_lines_src_out,
    input wire logic in_term_on_out,
    input wire logic [15:0] term_pulse_out,
    input wire logic [15:0] eq_high_out,
    input wire logic [1:0] emph_level_out,
    input wire logic emph_active_out,
    input wire logic out_term_on_out,
    input wire logic out_drive_high_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (srst_in);

    // Set when outputs must show the straps of two edges ago
    logic [1:0] gate_ff;
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            gate_ff <= 2'h0;
        end else begin
            gate_ff <= {gate_ff[0], strap_active_out && !ser_wr_in && !ser_rd_in};
        end
    end

    a_fast_route: assert property (
        gate_ff[1] |-> fast_mode_out == 4'h0 && fast_path_on_out == $past(strap_fast_path_on_in, 2)
        && fast_src_onehot_out == ($past(strap_fast_path_on_in, 2) ? 4'h1 << $past(strap_source_sel_in, 2) : 4'h0))
        else $error("fast path does not follow straps");
    a_side_route: assert property (
        gate_ff[1] |-> side_path_on_out && side_mode_out == 4'h0
        && side_common_lines_src_out == 4'h1 << $past(strap_source_sel_in, 2))
        else $error("side path does not follow straps");
    a_rx_forced: assert property (
        gate_ff[1] |-> in_term_on_out && term_pulse_out == 16'h0000)
        else $error("input termination not forced");
    a_eq_copy: assert property (
        gate_ff[1] |-> eq_high_out == {16{$past(strap_eq_high_in, 2)}})
        else $error("equalizer bits differ from strap");
    a_tx_straps: assert property (
        gate_ff[1] |-> emph_level_out == $past(strap_emph_level_in, 2)
        && emph_active_out == ($past(strap_emph_level_in, 2) != 2'h0)
        && out_term_on_out == $past(strap_out_term_on_in, 2)
        && out_drive_high_out == $past(strap_out_drive_high_in, 2))
        else $error("transmitter outputs differ from straps");
    a_access_ends: assert property (
        strap_active_out && (ser_wr_in || ser_rd_in) |=> !strap_active_out)
        else $error("access did not end strap mode");
    a_serial_stays: assert property (
        !strap_active_out && !srst_in |=> !strap_active_out)
        else $error("strap mode returned without reset");
    a_reset_strap: assert property (
        $fell(srst_in) |-> strap_active_out)
        else $error("strap mode not active after reset");
    a_frozen_out: assert property (
        (!strap_active_out && !ser_wr_in && !srst_in)[*2] |=> $stable(eq_high_out) && $stable(fast_src_onehot_out))
        else $error("outputs moved while frozen");

    c_strap_route: cover property (gate_ff[1] && fast_path_on_out);
    c_write_freeze: cover property (strap_active_out && ser_wr_in);
    c_read_freeze: cover property (strap_active_out && ser_rd_in);
endmodule

// File: test_pin_strap_switch_config.sv
/*
 * Self-checking bench for the strap configuration loader.
 * Assumes the strap board model and the checker are compiled first.
 */
`timescale 1ns/1ps
module test_pin_strap_switch_config;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic [7:0] level = 8'h00;
    logic [7:0] pin;
    logic ser_wr_in = 1'b0;
    logic ser_rd_in = 1'b0;
    logic [2:0] ser_addr_in = 3'h0;
    logic [7:0] ser_wdata_in = 8'h00;
    logic [7:0] ser_rdata_out;
    logic ser_rvalid_out, strap_active_out, fast_path_on_out, side_path_on_out;
    logic in_term_on_out, emph_active_out, out_term_on_out, out_drive_high_out;
    logic [3:0] fast_mode_out, fast_src_onehot_out, side_mode_out, side_common_lines_src_out;
    logic [15:0] term_pulse_out, eq_high_out;
    logic [1:0] emph_level_out;
    int failures = 0;
    int cmp_count = 0;

    always #5 clk_in = ~clk_in;

    // Pin order: enable, source[1:0], eq, emphasis[1:0], out term, drive
    pstc_strap_board board (.level_in(level), .pin_out(pin));
    pstc_top uut (.strap_fast_path_on_in(pin[7]), .strap_source_sel_in(pin[6:5]), .strap_eq_high_in(pin[4]),
        .strap_emph_level_in(pin[3:2]), .strap_out_term_on_in(pin[1]), .strap_out_drive_high_in(pin[0]), .*);

    task automatic print_verdict();
        $display("Comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Two edges to reach the outputs, one spare
    task automatic straps(input logic [7:0] v);
        @(posedge clk_in);
        level <= v;
        repeat (3) @(posedge clk_in);
        #1;
    endtask

    task automatic ser_acc(input logic wr, input logic [2:0] a, input logic [7:0] d);
        int n;
        @(posedge clk_in);
        ser_wr_in <= wr;
        ser_rd_in <= !wr;
        ser_addr_in <= a;
        ser_wdata_in <= d;
        @(posedge clk_in);
        ser_wr_in <= 1'b0;
        ser_rd_in <= 1'b0;
        n = 0;
        #1;
        while (!wr && ser_rvalid_out !== 1'b1 && n < 4) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        if (n == 4) begin
            failures++;
            print_verdict();
        end
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        ser_acc(1'b0, a, 8'h00);
        chk("rdata", 16'(exp), 16'(ser_rdata_out));
    endtask

    task automatic test_routing();
        for (int s = 0; s < 4; s++) begin
            straps({1'b1, 2'(s), 5'h00});
            chk("fast_src", 16'(4'h1 << s), 16'(fast_src_onehot_out));
            chk("side_src", 16'(4'h1 << s), 16'(side_common_lines_src_out));
            chk("ons", 16'h0003, 16'({fast_path_on_out, side_path_on_out}));
            chk("modes", 16'h0000, 16'({fast_mode_out, side_mode_out}));
        end
        straps(8'h40);
        chk("fast_off", 16'h0000, 16'({fast_path_on_out, fast_src_onehot_out}));
        chk("side_keep", 16'h0004, 16'(side_common_lines_src_out));
    endtask

    task automatic test_rx_tx();
        logic [7:0] v;
        for (int k = 0; k < 4; k++) begin
            v = {3'h4, 1'(k), 2'(k), 1'(k >> 1), ~1'(k)};
            straps(v);
            chk("eq", {16{v[4]}}, eq_high_out);
            chk("emph", 16'({v[3:2], 1'(v[3:2] != 2'h0)}), 16'({emph_level_out, emph_active_out}));
            chk("tx", 16'(v[1:0]), 16'({out_term_on_out, out_drive_high_out}));
            chk("pulse", 16'h0000, term_pulse_out);
            chk("in_term", 16'h0001, 16'(in_term_on_out));
        end
    endtask

    task automatic test_freeze();
        logic [7:0] img [8] = '{8'h41, 8'h41, 8'h01, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h05};
        straps(8'hB5);
        for (int i = 0; i < 8; i++) begin
            rd(3'(i), img[i]);
        end
        chk("strap_active", 16'h0000, 16'(strap_active_out));
        straps(8'h00);
        chk("frozen", 16'hFFF2, {eq_high_out[11:0], fast_src_onehot_out});
        rd(3'h7, 8'h05);
        ser_acc(1'b1, 3'h7, 8'h0E);
        rd(3'h7, 8'h0E);
        chk("tx_ser", 16'h001E, 16'({emph_level_out, emph_active_out, out_term_on_out, out_drive_high_out}));
        ser_acc(1'b1, 3'h7, 8'h01);
        @(posedge clk_in);
        #1;
        chk("tx_ser", 16'h0001, 16'({out_term_on_out, out_drive_high_out}));
    endtask

    task automatic test_reset_write();
        @(posedge clk_in);
        level <= 8'hE0;
        srst_in <= 1'b1;
        @(posedge clk_in);
        srst_in <= 1'b0;
        #1;
        chk("in_reset", 16'h0010, 16'({strap_active_out, fast_src_onehot_out}));
        straps(8'hE0);
        chk("restored", 16'h0008, 16'(fast_src_onehot_out));
        ser_acc(1'b1, 3'h7, 8'h08);
        chk("strap_active", 16'h0000, 16'(strap_active_out));
        rd(3'h7, 8'h08);
        // A non-quad mode field written serially must drop the one-hot route
        ser_acc(1'b1, 3'h0, 8'h47);
        @(posedge clk_in);
        #1;
        chk("fast_other", 16'h0110, 16'({fast_path_on_out, fast_mode_out, fast_src_onehot_out}));
    endtask

    initial begin
        repeat (2) @(posedge clk_in);
        srst_in <= 1'b0;
        test_routing();
        test_rx_tx();
        test_freeze();
        test_reset_write();
        print_verdict();
    end
endmodule

bind pstc_top pstc_top_chk chk_i (.*);
